// File: shared/tmpwm_pkg.sv
// Package for the period timer and PWM block: register offsets, field positions, reset values.
// Assumes an 8-bit register port with byte-wide offsets as printed.
package tmpwm_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h0b;
    localparam logic [7:0] ADDR_PERIPHERAL_IRQ_FLAGS = 8'h0c;
    localparam logic [7:0] ADDR_TIMER_COUNT = 8'h11;
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h12;
    localparam logic [7:0] ADDR_COMPARE_LOW_BYTE = 8'h15;
    localparam logic [7:0] ADDR_COMPARE_HIGH_BYTE = 8'h16;
    localparam logic [7:0] ADDR_COMPARE_CONTROL = 8'h17;
    localparam logic [7:0] ADDR_COMPARE_PIN_DIRECTION = 8'h87;
    localparam logic [7:0] ADDR_PERIPHERAL_IRQ_ENABLES = 8'h8c;
    localparam logic [7:0] ADDR_TIMER_PERIOD = 8'h92;
    // Field positions
    localparam int TIMER_ON_BIT = 2;
    localparam int POSTSCALE_LSB = 3;
    localparam int PRESCALE_LSB = 0;
    localparam int DUTY_LSB_POS = 4;
    localparam int TIMER_MATCH_FLAG_BIT = 1;
    localparam int COMPARE_PIN_DIR_BIT = 2;
    // Implemented-bit masks; other bits read as zero
    localparam logic [7:0] MASK_TIMER_CONTROL = 8'h7f;
    localparam logic [7:0] MASK_COMPARE_CONTROL = 8'h3f;
    localparam logic [7:0] MASK_IRQ_BITS = 8'h4f;
    localparam logic [7:0] MASK_PIN_DIRECTION = 8'h05;
    // PWM mode selects compare_control_r bits 3:2 = 11
    localparam logic [1:0] PWM_MODE_CODE = 2'h3;
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_TIMER_PERIOD = 8'hff;
    localparam logic [7:0] RST_PIN_DIRECTION = 8'h05;
    // Instruction clock is a quarter of the block clock
    localparam int INSTR_DIV = 4;
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
endpackage

// File: src/tmpwm_prescaler.sv
// Prescaler: divides instruction-clock ticks by 1, 4 or 16.
// Assumes tick_in is a one-cycle pulse in the clock_in domain.
module tmpwm_prescaler (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // Control
    input wire logic tick_in,
    input wire logic clear_in,
    input wire logic [1:0] sel_in,
    // Divided tick
    output logic tick_out
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [3:0] last;

    ////////////////////////////////////////////////////////////////////////
    // Terminal count per code; 10 and 11 both give 16
    always_comb begin
        case (sel_in)
            2'h0: last = 4'h0;
            2'h1: last = 4'h3;
            default: last = 4'hf;
        endcase
        cnt_nxt = cnt_r;
        tick_out = 1'b0;
        if (clear_in) begin
            cnt_nxt = 4'h0;
        end else if (tick_in) begin
            if (cnt_r >= last) begin
                cnt_nxt = 4'h0;
                tick_out = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// File: src/tmpwm_timer2_pwm.sv
// Period timer with prescaler, postscaler, match flag and 10-bit PWM output.
// Assumes a single 125 MHz clock; the instruction clock is derived as clock/4.
module tmpwm_timer2_pwm (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // PWM pin
    output logic compare_pin_out,
    output logic compare_pin_oe_out,
    // Timer match interrupt request
    output logic timer_irq_out
);
    ////////////////////////////////////////////////////////////////////////
    // State
    // Software-visible registers, each with its next value
    logic [7:0] timer_count_r, timer_count_nxt;
    logic [7:0] timer_period_r, timer_period_nxt;
    logic [7:0] timer_control_r, timer_control_nxt;
    logic [7:0] compare_low_byte_r, compare_low_byte_nxt;
    logic [7:0] compare_high_byte_r, compare_high_byte_nxt;
    logic [7:0] compare_control_r, compare_control_nxt;
    logic [7:0] compare_pin_direction_r, compare_pin_direction_nxt;
    logic [7:0] interrupt_control_r, interrupt_control_nxt;
    logic [7:0] peripheral_irq_flags_r, peripheral_irq_flags_nxt;
    logic [7:0] peripheral_irq_enables_r, peripheral_irq_enables_nxt;
    // Time base: instruction phase, sub-count, postscaler, latched duty and pin level
    logic [1:0] instr_cnt_r, instr_cnt_nxt;
    logic [1:0] sub_r, sub_nxt;
    logic [3:0] post_cnt_r, post_cnt_nxt;
    logic [7:0] duty_hi_r, duty_hi_nxt;
    logic [1:0] duty_lo_r, duty_lo_nxt;
    logic pwm_r, pwm_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    // Decoded controls and single-cycle events
    logic timer_on;
    logic instr_tick;
    logic pre_tick;
    logic match;
    logic post_event;
    logic pwm_mode;
    logic [9:0] count10;

    assign timer_on = timer_control_r[tmpwm_pkg::TIMER_ON_BIT];
    assign pwm_mode = compare_control_r[3:2] == tmpwm_pkg::PWM_MODE_CODE;
    // Instruction clock tick, a quarter of the block clock
    assign instr_tick = instr_cnt_r == tmpwm_pkg::INSTR_DIV_LAST;
    assign match = timer_count_r == timer_period_r;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler, held clear while the timer is off so it restarts cleanly
    tmpwm_prescaler u_pre (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .tick_in(instr_tick & timer_on),
        .clear_in(~timer_on),
        .sel_in(timer_control_r[tmpwm_pkg::PRESCALE_LSB +: 2]),
        .tick_out(pre_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Counter, postscaler and PWM generation
    always_comb begin
        instr_cnt_nxt = instr_cnt_r + 2'h1;
        timer_count_nxt = timer_count_r;
        sub_nxt = sub_r;
        post_cnt_nxt = post_cnt_r;
        post_event = 1'b0;
        duty_hi_nxt = duty_hi_r;
        duty_lo_nxt = duty_lo_r;
        pwm_nxt = pwm_r;
        // 10-bit time base: count above a 2-bit phase. At prescale 1 the phase is the
        // block clock within the instruction cycle, so the duty LSBs are exact; at the
        // coarser prescales the instruction ticks since the last prescaled tick stand in
        if (timer_control_r[tmpwm_pkg::PRESCALE_LSB +: 2] == 2'h0) begin
            count10 = {timer_count_r, instr_cnt_r};
        end else begin
            count10 = {timer_count_r, sub_r};
        end
        // Sub-count advances on each instruction tick for 10-bit duty resolution
        if (timer_on && instr_tick) begin
            sub_nxt = sub_r + 2'h1;
        end
        if (pre_tick) begin
            sub_nxt = 2'h0;
            if (match) begin
                timer_count_nxt = 8'h00;
                // Duty is latched at period start so mid-cycle writes never glitch
                duty_hi_nxt = compare_low_byte_r;
                duty_lo_nxt = compare_control_r[tmpwm_pkg::DUTY_LSB_POS +: 2];
                // A zero duty never raises the pin, so no one-clock spike at period start
                pwm_nxt = {compare_low_byte_r, compare_control_r[tmpwm_pkg::DUTY_LSB_POS +: 2]} != 10'h000;
                if (post_cnt_r >= timer_control_r[tmpwm_pkg::POSTSCALE_LSB +: 4]) begin
                    post_cnt_nxt = 4'h0;
                    post_event = 1'b1;
                end else begin
                    post_cnt_nxt = post_cnt_r + 4'h1;
                end
            end else begin
                timer_count_nxt = timer_count_r + 8'h01;
            end
        end
        // Compare one clock ahead: the pin is a flop, so at prescale 1 this lowers it exactly when the
        // time base reaches the duty value rather than one clock late
        if (pwm_r && {1'b0, count10} + 11'h001 >= {1'b0, duty_hi_r, duty_lo_r}) begin
            pwm_nxt = 1'b0;
        end
        // Leaving pulse-width mode drops the pin at once, not at the next period
        if (!pwm_mode) begin
            pwm_nxt = 1'b0;
        end
        // A software write to the count wins over counting; sub-count restarts
        if (wr_in && addr_in == tmpwm_pkg::ADDR_TIMER_COUNT) begin
            timer_count_nxt = wdata_in;
            sub_nxt = 2'h0;
        end
        // Rewriting the control restarts the postscaler so a new ratio counts from zero
        if (wr_in && addr_in == tmpwm_pkg::ADDR_TIMER_CONTROL) begin
            post_cnt_nxt = 4'h0;
        end
    end

    // One register stage for the whole time base, so count, phase and pin move together
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            instr_cnt_r <= 2'h0;
            timer_count_r <= tmpwm_pkg::RST_ZERO;
            sub_r <= 2'h0;
            post_cnt_r <= 4'h0;
            duty_hi_r <= tmpwm_pkg::RST_ZERO;
            duty_lo_r <= 2'h0;
            pwm_r <= 1'b0;
        end else begin
            instr_cnt_r <= instr_cnt_nxt;
            timer_count_r <= timer_count_nxt;
            sub_r <= sub_nxt;
            post_cnt_r <= post_cnt_nxt;
            duty_hi_r <= duty_hi_nxt;
            duty_lo_r <= duty_lo_nxt;
            pwm_r <= pwm_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes; the flag set beats a simultaneous software clear
    always_comb begin
        timer_period_nxt = timer_period_r;
        timer_control_nxt = timer_control_r;
        compare_low_byte_nxt = compare_low_byte_r;
        compare_high_byte_nxt = compare_high_byte_r;
        compare_control_nxt = compare_control_r;
        compare_pin_direction_nxt = compare_pin_direction_r;
        interrupt_control_nxt = interrupt_control_r;
        peripheral_irq_flags_nxt = peripheral_irq_flags_r;
        peripheral_irq_enables_nxt = peripheral_irq_enables_r;
        // Unimplemented bits are masked on the way in, so reads need no masking
        if (wr_in) begin
            case (addr_in)
                tmpwm_pkg::ADDR_TIMER_PERIOD: timer_period_nxt = wdata_in;
                tmpwm_pkg::ADDR_TIMER_CONTROL: timer_control_nxt = wdata_in & tmpwm_pkg::MASK_TIMER_CONTROL;
                tmpwm_pkg::ADDR_COMPARE_LOW_BYTE: compare_low_byte_nxt = wdata_in;
                tmpwm_pkg::ADDR_COMPARE_HIGH_BYTE: compare_high_byte_nxt = wdata_in;
                tmpwm_pkg::ADDR_COMPARE_CONTROL: compare_control_nxt = wdata_in & tmpwm_pkg::MASK_COMPARE_CONTROL;
                tmpwm_pkg::ADDR_COMPARE_PIN_DIRECTION: begin
                    compare_pin_direction_nxt = wdata_in & tmpwm_pkg::MASK_PIN_DIRECTION;
                end
                tmpwm_pkg::ADDR_INTERRUPT_CONTROL: interrupt_control_nxt = wdata_in;
                tmpwm_pkg::ADDR_PERIPHERAL_IRQ_FLAGS: peripheral_irq_flags_nxt = wdata_in & tmpwm_pkg::MASK_IRQ_BITS;
                tmpwm_pkg::ADDR_PERIPHERAL_IRQ_ENABLES: begin
                    peripheral_irq_enables_nxt = wdata_in & tmpwm_pkg::MASK_IRQ_BITS;
                end
                default: begin
                end
            endcase
        end
        // Applied after the decode so the hardware set wins over a software clear
        if (post_event) begin
            peripheral_irq_flags_nxt[tmpwm_pkg::TIMER_MATCH_FLAG_BIT] = 1'b1;
        end
    end

    // Period resets to all ones so a timer started without set-up runs the full range
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            timer_period_r <= tmpwm_pkg::RST_TIMER_PERIOD;
            timer_control_r <= tmpwm_pkg::RST_ZERO;
            compare_low_byte_r <= tmpwm_pkg::RST_ZERO;
            compare_high_byte_r <= tmpwm_pkg::RST_ZERO;
            compare_control_r <= tmpwm_pkg::RST_ZERO;
            compare_pin_direction_r <= tmpwm_pkg::RST_PIN_DIRECTION;
            interrupt_control_r <= tmpwm_pkg::RST_ZERO;
            peripheral_irq_flags_r <= tmpwm_pkg::RST_ZERO;
            peripheral_irq_enables_r <= tmpwm_pkg::RST_ZERO;
        end else begin
            timer_period_r <= timer_period_nxt;
            timer_control_r <= timer_control_nxt;
            compare_low_byte_r <= compare_low_byte_nxt;
            compare_high_byte_r <= compare_high_byte_nxt;
            compare_control_r <= compare_control_nxt;
            compare_pin_direction_r <= compare_pin_direction_nxt;
            interrupt_control_r <= interrupt_control_nxt;
            peripheral_irq_flags_r <= peripheral_irq_flags_nxt;
            peripheral_irq_enables_r <= peripheral_irq_enables_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe; masks keep unused bits zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (rd_in) begin
            case (addr_in)
                tmpwm_pkg::ADDR_TIMER_COUNT: rdata_nxt = timer_count_r;
                tmpwm_pkg::ADDR_TIMER_PERIOD: rdata_nxt = timer_period_r;
                tmpwm_pkg::ADDR_TIMER_CONTROL: rdata_nxt = timer_control_r;
                tmpwm_pkg::ADDR_COMPARE_LOW_BYTE: rdata_nxt = compare_low_byte_r;
                tmpwm_pkg::ADDR_COMPARE_HIGH_BYTE: rdata_nxt = compare_high_byte_r;
                tmpwm_pkg::ADDR_COMPARE_CONTROL: rdata_nxt = compare_control_r;
                tmpwm_pkg::ADDR_COMPARE_PIN_DIRECTION: rdata_nxt = compare_pin_direction_r;
                tmpwm_pkg::ADDR_INTERRUPT_CONTROL: rdata_nxt = interrupt_control_r;
                tmpwm_pkg::ADDR_PERIPHERAL_IRQ_FLAGS: rdata_nxt = peripheral_irq_flags_r;
                tmpwm_pkg::ADDR_PERIPHERAL_IRQ_ENABLES: rdata_nxt = peripheral_irq_enables_r;
                default: rdata_nxt = 8'h00; // Unmapped reads return zero
            endcase
        end
    end

    // Read data cleared between answers so a stale value is never taken for a reply
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; the pin is driven only while its direction bit is clear
    assign rdata_out = rdata_r;
    // The pin level is meaningful outside only while the enable drives it
    assign compare_pin_out = pwm_r;
    assign compare_pin_oe_out = ~compare_pin_direction_r[tmpwm_pkg::COMPARE_PIN_DIR_BIT];
    // Request needs flag, its enable, and peripheral (bit 6) plus global (bit 7) enables
    assign timer_irq_out = peripheral_irq_flags_r[tmpwm_pkg::TIMER_MATCH_FLAG_BIT]
        & peripheral_irq_enables_r[tmpwm_pkg::TIMER_MATCH_FLAG_BIT]
        & interrupt_control_r[6] & interrupt_control_r[7];
endmodule

// File: bench/tmpwm_monitor.sv
// Checker for the period timer and PWM block: register port and pin relations.
// Assumes it is bound to tmpwm_timer2_pwm and sees only that module's ports.
module tmpwm_monitor (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    // Pin and interrupt
    input wire logic compare_pin_out,
    input wire logic compare_pin_oe_out,
    input wire logic timer_irq_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    ////////////////////////////////////////////////////////////////////////////////
    // Steps of a write followed by a read of the period register
    sequence s_wr_period;
        wr_in && addr_in == tmpwm_pkg::ADDR_TIMER_PERIOD;
    endsequence
    sequence s_rd_period;
        rd_in && !wr_in && addr_in == tmpwm_pkg::ADDR_TIMER_PERIOD;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    // Read data and masking of unused bits
    a_rdata_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data not zero outside the answer cycle");
    a_period_read_back: assert property (s_wr_period ##1 !wr_in ##1 s_rd_period
        |=> rdata_out == $past(wdata_in, 3)) else $error("period register did not return the value written");
    a_unmapped_reads_zero: assert property (rd_in && !(addr_in inside {8'h0b, 8'h0c, 8'h11, 8'h12,
        8'h15, 8'h16, 8'h17, 8'h87, 8'h8c, 8'h92}) |=> rdata_out == 8'h00)
        else $error("unmapped address returned data");
    a_ctrl_top_zero: assert property (rd_in && addr_in == tmpwm_pkg::ADDR_TIMER_CONTROL
        |=> !rdata_out[7]) else $error("timer control bit 7 read as one");
    a_cctl_top_zero: assert property (rd_in && addr_in == tmpwm_pkg::ADDR_COMPARE_CONTROL
        |=> rdata_out[7:6] == 2'h0) else $error("compare control bits 7:6 read as one");
    a_dir_mask_zero: assert property (rd_in && addr_in == tmpwm_pkg::ADDR_COMPARE_PIN_DIRECTION
        |=> (rdata_out & 8'hfa) == 8'h00) else $error("pin direction unused bits read as one");
    a_irq_mask_zero: assert property (rd_in && addr_in inside {8'h0c, 8'h8c}
        |=> (rdata_out & 8'hb0) == 8'h00) else $error("interrupt register unused bits read as one");

    ////////////////////////////////////////////////////////////////////////////////
    // Pin driver follows direction and mode; writes settle within two edges
    a_pin_oe_follow: assert property (wr_in && addr_in == tmpwm_pkg::ADDR_COMPARE_PIN_DIRECTION
        |-> ##2 compare_pin_oe_out == !$past(wdata_in[2], 2))
        else $error("pin enable does not follow direction bit");
    a_pwm_off_low: assert property (wr_in && addr_in == tmpwm_pkg::ADDR_COMPARE_CONTROL
        && wdata_in[3:2] != 2'h3 |-> ##2 !compare_pin_out) else $error("pin high outside pulse width mode");
endmodule

bind tmpwm_timer2_pwm tmpwm_monitor mon (.clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .compare_pin_out(compare_pin_out),
    .compare_pin_oe_out(compare_pin_oe_out), .timer_irq_out(timer_irq_out));

// File: bench/tb.sv
// Self-checking bench for the period timer and PWM block.
// Assumes the register port answers reads one cycle later and never stalls.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic compare_pin_out;
    logic compare_pin_oe_out;
    logic timer_irq_out;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    int d;
    // Address, reset value and value read back after writing all ones
    logic [7:0] ra [11] = '{8'h11, 8'h92, 8'h12, 8'h17, 8'h0c, 8'h8c, 8'h0b, 8'h15, 8'h16, 8'h87, 8'h40};
    logic [7:0] rv [11] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00};
    logic [7:0] rm [11] = '{8'hff, 8'hff, 8'h7f, 8'h3f, 8'h4f, 8'h4f, 8'hff, 8'hff, 8'hff, 8'h05, 8'h00};

    tmpwm_timer2_pwm dut (.clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .compare_pin_out(compare_pin_out),
        .compare_pin_oe_out(compare_pin_oe_out), .timer_irq_out(timer_irq_out));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the whole run needs well under 20000 cycles
    always #4 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus cycles and comparison
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
        // Let the write settle before a caller looks at the outputs
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 check($sformatf("register %h", a), exp, rdata_out);
    endtask
    // Time from enabling the timer to the interrupt, in clocks, against instruction ticks
    task automatic run_timer(input logic [7:0] per, input logic [7:0] ctl, input int ticks);
        wr(8'h12, 8'h00);
        wr(8'h11, 8'h00);
        wr(8'h0c, 8'h00);
        wr(8'h92, per);
        wr(8'h12, ctl);
        n = 0;
        while (timer_irq_out !== 1'b1 && n < 5000) begin
            @(posedge clock_in);
            n++;
        end
        check("irq delay in range", 1, (n >= 4 * ticks - 4 && n <= 4 * ticks + 6));
    endtask
    // Clocks with the pin high over a 256-clock window
    task automatic pwm_high(input int exp);
        repeat (128) @(posedge clock_in);
        n = 0;
        repeat (256) begin
            @(posedge clock_in);
            n += (compare_pin_out === 1'b1);
        end
        check("pwm high clocks in range", 1, (n >= exp - 6 && n <= exp + 6));
    endtask
    task automatic stop_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge clock_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 11; i++) rd(ra[i], rv[i]);
        for (int i = 0; i < 11; i++) begin
            wr(ra[i], 8'hff);
            rd(ra[i], rm[i]);
        end
        check("irq all enabled", 1, timer_irq_out);
        wr(8'h8c, 8'h00);
        check("irq masked", 0, timer_irq_out);
        wr(8'h8c, 8'h02);
        wr(8'h0b, 8'hc0);
        // Every prescale code, then both postscale ends
        for (int c = 0; c < 4; c++) begin
            d = (c == 0) ? 1 : (c == 1) ? 4 : 16;
            run_timer(8'h02, 8'h0c | c[7:0], 3 * d * 2);
        end
        run_timer(8'h00, 8'h04, 1);
        run_timer(8'h00, 8'h7c, 16);
        wr(8'h0c, 8'h00);
        check("irq after clear", 0, timer_irq_out);
        // Stopped timer holds a written count
        wr(8'h12, 8'h00);
        wr(8'h11, 8'h2a);
        repeat (40) @(posedge clock_in);
        rd(8'h11, 8'h2a);
        // Start the time base from zero so the first period comes at once
        wr(8'h11, 8'h00);
        // PWM set-up in the documented order, two duty values
        wr(8'h92, 8'h03);
        wr(8'h15, 8'h01);
        wr(8'h87, 8'h00);
        wr(8'h12, 8'h04);
        wr(8'h17, 8'h0c);
        check("pin enable", 1, compare_pin_oe_out);
        pwm_high(64);
        wr(8'h15, 8'h02);
        wr(8'h17, 8'h2c);
        pwm_high(160);
        wr(8'h17, 8'h20);
        pwm_high(0);
        stop_test();
    end
endmodule
